// [verilog/crs_sched.sv]
// CAN report scheduler: single slots, bulk blocks, AXI4-Lite registers
// Contract
// RQ1: single slots go out in index order with ids base plus index.
// RQ2: a single slot holding address zero sends nothing.
// RQ3: software keeps every assigned id inside eleven bits.
// RQ4: four independent bulk blocks exist beside the single slots.
// RQ5: bulk frames look exactly like single-slot frames.
// RQ6: a bulk block reads from its start address; zero disables it.
// RQ7: a bulk block reads its gate register to decide each transmission; the code sends every element without a gate read when the gate address is zero.
// RQ8: data and gate addresses both advance by the stride.
// RQ9: a bulk block handles exactly its count of registers.
// RQ10: bulk frames go out in order with consecutive ids.
// RQ11: block zero starts at base id plus 64.
// RQ12: each later block starts after all earlier blocks' counts.
// RQ13: a count change moves the start ids of later blocks.
// RQ14: software sizes cell counts to the full provisioned span.
// RQ15: software makes cell counts a multiple of sixteen.
// RQ16: software makes thermistor counts a multiple of eight.
// RQ17: a gated-off element is skipped but keeps its id.
//
// Added by the designer: the register offsets and the AXI4-Lite interface to the registers.
`timescale 1ns/1ns
`default_nettype none
module crs_sched (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// axi4-lite slave
	input wire logic [crs_pkg::CRS_ADDR_W-1:0] s_awaddr,
	input wire logic s_awvalid,
	output logic s_awready,
	input wire logic [31:0] s_wdata,
	input wire logic [3:0] s_wstrb,
	input wire logic s_wvalid,
	output logic s_wready,
	output logic [1:0] s_bresp,
	output logic s_bvalid,
	input wire logic s_bready,
	input wire logic [crs_pkg::CRS_ADDR_W-1:0] s_araddr,
	input wire logic s_arvalid,
	output logic s_arready,
	output logic [31:0] s_rdata,
	output logic [1:0] s_rresp,
	output logic s_rvalid,
	input wire logic s_rready,
	// device register read port
	output logic dev_rd_req,
	output logic [31:0] dev_rd_addr,
	input wire logic dev_rd_ack,
	input wire logic [31:0] dev_rd_data,
	// frame stream to the CAN transmitter
	output logic tx_valid,
	input wire logic tx_ready,
	output logic [crs_pkg::CRS_ID_W-1:0] tx_id,
	output logic [crs_pkg::CRS_DATA_W-1:0] tx_data
);
	import crs_pkg::*;

	// ****************************************
	// register file
	// ****************************************
	logic [31:0] slot_reg [CRS_SLOTS];
	logic [31:0] slot_next [CRS_SLOTS];
	logic [31:0] bulk_reg [CRS_BLOCKS][4];
	logic [31:0] bulk_next [CRS_BLOCKS][4];
	logic run_reg, run_next, once_reg, once_next;
	logic [10:0] base_id_reg, base_id_next;
	logic [31:0] sent_reg, sent_next;
	logic aw_have_reg, aw_have_next, w_have_reg, w_have_next;
	logic [11:0] aw_addr_reg, aw_addr_next;
	logic [31:0] w_data_reg, w_data_next;
	logic [3:0] w_strb_reg, w_strb_next;
	logic awready_reg, awready_next, wready_reg, wready_next;
	logic bvalid_reg, bvalid_next, arready_reg, arready_next, rvalid_reg, rvalid_next;
	logic [1:0] bresp_reg, bresp_next, rresp_reg, rresp_next;
	logic [31:0] rdata_reg, rdata_next;
	// ****************************************
	// scheduler state
	// ****************************************
	crs_state_t st_reg, st_next;
	logic bulk_ph_reg, bulk_ph_next;
	logic [6:0] idx_reg, idx_next;
	logic [2:0] blk_reg, blk_next;
	logic [31:0] elem_reg, elem_next, acc_reg, acc_next;
	logic req_reg, req_next;
	logic [31:0] rd_addr_reg, rd_addr_next, fr_data_reg, fr_data_next;
	logic [10:0] fr_id_reg, fr_id_next;
	logic [10:0] start_id [CRS_BLOCKS];
	logic fifo_ready, commit;
	logic [31:0] wmask, cur_start, cur_gate, cur_stride, cur_count;

	assign s_awready = awready_reg;
	assign s_wready = wready_reg;
	assign s_bvalid = bvalid_reg;
	assign s_bresp = bresp_reg;
	assign s_arready = arready_reg;
	assign s_rvalid = rvalid_reg;
	assign s_rdata = rdata_reg;
	assign s_rresp = rresp_reg;
	assign dev_rd_req = req_reg;
	assign dev_rd_addr = rd_addr_reg;

	// block start ids follow the counts every cycle, so a count write moves later blocks
	always_comb begin
		start_id[0] = base_id_reg + CRS_BULK_ID_GAP; // see RQ11 // see RQ3
		for (int b = 1; b < CRS_BLOCKS; b++) begin
			start_id[b] = start_id[b-1] + bulk_reg[b-1][CRS_BF_COUNT][10:0]; // see RQ12 // see RQ13
		end
	end

	// ****************************************
	// axi4-lite slave
	// ****************************************
	always_comb begin
		slot_next = slot_reg;
		bulk_next = bulk_reg;
		run_next = run_reg;
		base_id_next = base_id_reg;
		once_next = once_reg & ~(st_reg == CRS_ST_IDLE);
		aw_have_next = aw_have_reg | (s_awvalid & awready_reg);
		w_have_next = w_have_reg | (s_wvalid & wready_reg);
		aw_addr_next = (s_awvalid & awready_reg) ? s_awaddr : aw_addr_reg;
		w_data_next = (s_wvalid & wready_reg) ? s_wdata : w_data_reg;
		w_strb_next = (s_wvalid & wready_reg) ? s_wstrb : w_strb_reg;
		bvalid_next = bvalid_reg & ~s_bready;
		bresp_next = bresp_reg;
		wmask = {{8{w_strb_reg[3]}}, {8{w_strb_reg[2]}}, {8{w_strb_reg[1]}}, {8{w_strb_reg[0]}}};
		commit = aw_have_reg & w_have_reg & ~bvalid_reg;
		if (commit) begin
			aw_have_next = 1'b0;
			w_have_next = 1'b0;
			bvalid_next = 1'b1;
			bresp_next = CRS_RESP_OKAY;
			if (aw_addr_reg == CRS_OFF_CTRL) begin
				if (w_strb_reg[0]) begin
					run_next = w_data_reg[CRS_CTRL_RUN_BIT];
					// a start request in the same cycle as the round launch survives
					once_next = once_next | w_data_reg[CRS_CTRL_ONCE_BIT];
				end
			end else if (aw_addr_reg == CRS_OFF_BASE_ID) begin
				base_id_next = 11'(({21'h0, base_id_reg} & ~wmask) | (w_data_reg & wmask));
			end else if (aw_addr_reg >= CRS_OFF_BULK && aw_addr_reg <= CRS_OFF_BULK_END) begin
				bulk_next[aw_addr_reg[5:4]][aw_addr_reg[3:2]] =
					(bulk_reg[aw_addr_reg[5:4]][aw_addr_reg[3:2]] & ~wmask) | (w_data_reg & wmask);
			end else if (aw_addr_reg >= CRS_OFF_SLOT && aw_addr_reg <= CRS_OFF_SLOT_END) begin
				slot_next[aw_addr_reg[7:2]] = (slot_reg[aw_addr_reg[7:2]] & ~wmask) | (w_data_reg & wmask);
			end else if (aw_addr_reg != CRS_OFF_STATUS && aw_addr_reg != CRS_OFF_SENT) begin
				bresp_next = CRS_RESP_SLVERR;
			end
		end
		awready_next = ~aw_have_next;
		wready_next = ~w_have_next;
		rvalid_next = rvalid_reg & ~s_rready;
		rdata_next = rdata_reg;
		rresp_next = rresp_reg;
		if (s_arvalid & arready_reg) begin
			rvalid_next = 1'b1;
			rresp_next = CRS_RESP_OKAY;
			rdata_next = CRS_WORD_RST;
			if (s_araddr == CRS_OFF_CTRL) begin
				rdata_next[CRS_CTRL_RUN_BIT] = run_reg;
			end else if (s_araddr == CRS_OFF_BASE_ID) begin
				rdata_next = {21'h0, base_id_reg};
			end else if (s_araddr == CRS_OFF_STATUS) begin
				rdata_next[CRS_STAT_BUSY_BIT] = st_reg != CRS_ST_IDLE;
				rdata_next[CRS_STAT_PEND_BIT] = once_reg;
			end else if (s_araddr == CRS_OFF_SENT) begin
				rdata_next = sent_reg;
			end else if (s_araddr >= CRS_OFF_BULK && s_araddr <= CRS_OFF_BULK_END) begin
				rdata_next = bulk_reg[s_araddr[5:4]][s_araddr[3:2]];
			end else if (s_araddr >= CRS_OFF_SLOT && s_araddr <= CRS_OFF_SLOT_END) begin
				rdata_next = slot_reg[s_araddr[7:2]];
			end else begin
				rresp_next = CRS_RESP_SLVERR;
			end
		end
		arready_next = ~rvalid_next;
	end

	// ****************************************
	// scheduler
	// ****************************************
	always_comb begin
		cur_start = bulk_reg[blk_reg[1:0]][CRS_BF_START];
		cur_gate = bulk_reg[blk_reg[1:0]][CRS_BF_GATE];
		cur_stride = bulk_reg[blk_reg[1:0]][CRS_BF_STRIDE];
		cur_count = bulk_reg[blk_reg[1:0]][CRS_BF_COUNT];
		st_next = st_reg;
		bulk_ph_next = bulk_ph_reg;
		idx_next = idx_reg;
		blk_next = blk_reg;
		elem_next = elem_reg;
		acc_next = acc_reg;
		req_next = req_reg & ~dev_rd_ack;
		rd_addr_next = rd_addr_reg;
		fr_data_next = fr_data_reg;
		fr_id_next = fr_id_reg;
		sent_next = sent_reg;
		case (st_reg)
			CRS_ST_IDLE: begin
				if (run_reg | once_reg) begin
					bulk_ph_next = 1'b0;
					idx_next = '0;
					st_next = CRS_ST_SLOT;
				end
			end
			CRS_ST_SLOT: begin
				if (idx_reg == 7'(CRS_SLOTS)) begin
					bulk_ph_next = 1'b1;
					blk_next = '0;
					elem_next = '0;
					acc_next = '0;
					st_next = CRS_ST_BULK;
				end else if (slot_reg[idx_reg[5:0]] == CRS_WORD_RST) begin
					idx_next = idx_reg + 7'h01; // see RQ2
				end else begin
					req_next = 1'b1;
					rd_addr_next = slot_reg[idx_reg[5:0]];
					fr_id_next = base_id_reg + {4'h0, idx_reg}; // see RQ1
					st_next = CRS_ST_DATA;
				end
			end
			CRS_ST_BULK: begin
				if (blk_reg == 3'(CRS_BLOCKS)) begin // see RQ4
					st_next = CRS_ST_IDLE;
				end else if (cur_start == CRS_WORD_RST || elem_reg >= cur_count) begin
					blk_next = blk_reg + 3'h1; // see RQ6 // see RQ9
					elem_next = '0;
					acc_next = '0;
				end else begin
					req_next = 1'b1;
					fr_id_next = start_id[blk_reg[1:0]] + elem_reg[10:0]; // see RQ10
					if (cur_gate == CRS_WORD_RST) begin
						// no gate register configured: element always sent
						rd_addr_next = cur_start + acc_reg;
						st_next = CRS_ST_DATA;
					end else begin
						rd_addr_next = cur_gate + acc_reg; // see RQ7
						st_next = CRS_ST_GATE;
					end
				end
			end
			CRS_ST_GATE: begin
				if (dev_rd_ack) begin
					if (dev_rd_data == CRS_WORD_RST) begin
						// id slot stays consumed so later ids do not shift
						elem_next = elem_reg + 32'h0000_0001; // see RQ17
						acc_next = acc_reg + cur_stride; // see RQ8
						st_next = CRS_ST_BULK;
					end else begin
						req_next = 1'b1;
						rd_addr_next = cur_start + acc_reg; // see RQ6
						st_next = CRS_ST_DATA;
					end
				end
			end
			CRS_ST_DATA: begin
				if (dev_rd_ack) begin
					fr_data_next = dev_rd_data;
					st_next = CRS_ST_PUSH;
				end
			end
			CRS_ST_PUSH: begin
				if (fifo_ready) begin
					sent_next = sent_reg + 32'h0000_0001;
					if (bulk_ph_reg) begin
						elem_next = elem_reg + 32'h0000_0001;
						acc_next = acc_reg + cur_stride; // see RQ8
						st_next = CRS_ST_BULK;
					end else begin
						idx_next = idx_reg + 7'h01;
						st_next = CRS_ST_SLOT;
					end
				end
			end
			default: begin
				st_next = CRS_ST_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk_sys) begin
		if (!rst_n) begin
			for (int i = 0; i < CRS_SLOTS; i++) begin
				slot_reg[i] <= CRS_WORD_RST;
			end
			for (int b = 0; b < CRS_BLOCKS; b++) begin
				for (int f = 0; f < 4; f++) begin
					bulk_reg[b][f] <= CRS_WORD_RST;
				end
			end
			run_reg <= 1'b0;
			once_reg <= 1'b0;
			base_id_reg <= CRS_BASE_ID_RST;
			sent_reg <= CRS_WORD_RST;
			aw_have_reg <= 1'b0;
			w_have_reg <= 1'b0;
			aw_addr_reg <= '0;
			w_data_reg <= CRS_WORD_RST;
			w_strb_reg <= '0;
			awready_reg <= 1'b0;
			wready_reg <= 1'b0;
			bvalid_reg <= 1'b0;
			bresp_reg <= CRS_RESP_OKAY;
			arready_reg <= 1'b0;
			rvalid_reg <= 1'b0;
			rdata_reg <= CRS_WORD_RST;
			rresp_reg <= CRS_RESP_OKAY;
			st_reg <= CRS_ST_IDLE;
			bulk_ph_reg <= 1'b0;
			idx_reg <= '0;
			blk_reg <= '0;
			elem_reg <= CRS_WORD_RST;
			acc_reg <= CRS_WORD_RST;
			req_reg <= 1'b0;
			rd_addr_reg <= CRS_WORD_RST;
			fr_data_reg <= CRS_WORD_RST;
			fr_id_reg <= '0;
		end else begin
			slot_reg <= slot_next;
			bulk_reg <= bulk_next;
			run_reg <= run_next;
			once_reg <= once_next;
			base_id_reg <= base_id_next;
			sent_reg <= sent_next;
			aw_have_reg <= aw_have_next;
			w_have_reg <= w_have_next;
			aw_addr_reg <= aw_addr_next;
			w_data_reg <= w_data_next;
			w_strb_reg <= w_strb_next;
			awready_reg <= awready_next;
			wready_reg <= wready_next;
			bvalid_reg <= bvalid_next;
			bresp_reg <= bresp_next;
			arready_reg <= arready_next;
			rvalid_reg <= rvalid_next;
			rdata_reg <= rdata_next;
			rresp_reg <= rresp_next;
			st_reg <= st_next;
			bulk_ph_reg <= bulk_ph_next;
			idx_reg <= idx_next;
			blk_reg <= blk_next;
			elem_reg <= elem_next;
			acc_reg <= acc_next;
			req_reg <= req_next;
			rd_addr_reg <= rd_addr_next;
			fr_data_reg <= fr_data_next;
			fr_id_reg <= fr_id_next;
		end
	end

	// ****************************************
	// frame buffer: one format for both report kinds
	// ****************************************
	crs_fifo #(.WIDTH(CRS_FRAME_W), .DEPTH(CRS_FIFO_DEPTH)) u_fifo (
		.clk_sys(clk_sys),
		.rst_n(rst_n),
		.in_valid(st_reg == CRS_ST_PUSH),
		.in_ready(fifo_ready),
		.in_data({fr_id_reg, fr_data_reg}), // see RQ5
		.out_valid(tx_valid),
		.out_ready(tx_ready),
		.out_data({tx_id, tx_data})
	);

	// ****************************************
	// checks
	// ****************************************
	slot_skip_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RQ2
		(st_reg == CRS_ST_SLOT && idx_reg < 7'(CRS_SLOTS) && slot_reg[idx_reg[5:0]] == 32'h0000_0000)
		|=> (!req_reg && idx_reg == $past(idx_reg) + 7'h01)) else $error("empty slot was read");
	slot_id_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RQ1
		(st_reg == CRS_ST_PUSH && !bulk_ph_reg) |-> fr_id_reg == base_id_reg + {4'h0, idx_reg})
		else $error("slot id not base plus index");
	bulk_id_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RQ11
		(st_reg == CRS_ST_PUSH && bulk_ph_reg && blk_reg == 3'h0)
		|-> fr_id_reg == base_id_reg + 11'h040 + elem_reg[10:0]) else $error("block zero id wrong");
	later_start_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RQ13
		(st_reg == CRS_ST_PUSH && bulk_ph_reg && blk_reg == 3'h1) |-> fr_id_reg == base_id_reg
		+ 11'h040 + bulk_reg[0][3][10:0] + elem_reg[10:0]) else $error("later start id not moved");
	stride_step_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RQ8
		(st_reg == CRS_ST_PUSH && bulk_ph_reg && fifo_ready)
		|=> acc_reg == $past(acc_reg) + $past(cur_stride)) else $error("stride not applied");
	block_off_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RQ6
		(st_reg == CRS_ST_BULK && blk_reg < 3'h4 && cur_start == 32'h0000_0000)
		|=> (blk_reg == $past(blk_reg) + 3'h1 && !req_reg)) else $error("disabled block read");
	gate_skip_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RQ17
		(st_reg == CRS_ST_GATE && dev_rd_ack && dev_rd_data == 32'h0000_0000)
		|=> (st_reg == CRS_ST_BULK && elem_reg == $past(elem_reg) + 32'h0000_0001))
		else $error("gated element not skipped");
	count_end_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RQ9
		(st_reg == CRS_ST_BULK && blk_reg < 3'h4 && elem_reg >= cur_count)
		|=> (elem_reg == 32'h0000_0000 && st_reg != CRS_ST_GATE)) else $error("count overrun");
	block_range_a: assert property (@(posedge clk_sys) disable iff (!rst_n) // see RQ4
		blk_reg <= 3'h4) else $error("block index out of range");
endmodule
`default_nettype wire

// [pkg/crs_pkg.sv]
// constants, register map and state codes for the CAN report scheduler
package crs_pkg;
	// ****************************************
	// geometry
	// ****************************************
	localparam int CRS_SLOTS = 64;
	localparam int CRS_BLOCKS = 4;
	localparam int CRS_ID_W = 11;
	localparam int CRS_DATA_W = 32;
	localparam int CRS_FRAME_W = CRS_ID_W + CRS_DATA_W;
	localparam int CRS_FIFO_DEPTH = 16;
	localparam logic [10:0] CRS_BULK_ID_GAP = 11'h040;
	// ****************************************
	// register map (byte addresses)
	// ****************************************
	localparam int CRS_ADDR_W = 12;
	localparam logic [11:0] CRS_OFF_CTRL = 12'h000;
	localparam logic [11:0] CRS_OFF_BASE_ID = 12'h004;
	localparam logic [11:0] CRS_OFF_STATUS = 12'h008;
	localparam logic [11:0] CRS_OFF_SENT = 12'h00C;
	localparam logic [11:0] CRS_OFF_BULK = 12'h040;
	localparam logic [11:0] CRS_OFF_BULK_END = 12'h07C;
	localparam logic [11:0] CRS_OFF_SLOT = 12'h100;
	localparam logic [11:0] CRS_OFF_SLOT_END = 12'h1FC;
	// bulk field index within a block's four words
	localparam logic [1:0] CRS_BF_START = 2'h0;
	localparam logic [1:0] CRS_BF_GATE = 2'h1;
	localparam logic [1:0] CRS_BF_STRIDE = 2'h2;
	localparam logic [1:0] CRS_BF_COUNT = 2'h3;
	// control and status bits
	localparam int CRS_CTRL_RUN_BIT = 0;
	localparam int CRS_CTRL_ONCE_BIT = 1;
	localparam int CRS_STAT_BUSY_BIT = 0;
	localparam int CRS_STAT_PEND_BIT = 1;
	// reset values
	localparam logic [31:0] CRS_WORD_RST = 32'h0000_0000;
	localparam logic [10:0] CRS_BASE_ID_RST = 11'h000;
	// bus answers
	localparam logic [1:0] CRS_RESP_OKAY = 2'h0;
	localparam logic [1:0] CRS_RESP_SLVERR = 2'h2;
	// ****************************************
	// scheduler states
	// ****************************************
	typedef enum logic [5:0] {
		CRS_ST_IDLE = 6'b00_0001,
		CRS_ST_SLOT = 6'b00_0010,
		CRS_ST_BULK = 6'b00_0100,
		CRS_ST_GATE = 6'b00_1000,
		CRS_ST_DATA = 6'b01_0000,
		CRS_ST_PUSH = 6'b10_0000
	} crs_state_t;
endpackage

// [verilog/crs_fifo.sv]
// frame FIFO with a registered output stage
`timescale 1ns/1ns
`default_nettype none
module crs_fifo #(
	parameter int WIDTH = 43,
	parameter int DEPTH = 16
) (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [WIDTH-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [WIDTH-1:0] out_data
);
	localparam int AW = $clog2(DEPTH);
	logic [WIDTH-1:0] mem [DEPTH];
	logic [AW-1:0] wptr_reg, wptr_next, rptr_reg, rptr_next;
	logic [AW:0] cnt_reg, cnt_next;
	logic in_ready_reg, in_ready_next;
	logic out_valid_reg, out_valid_next;
	logic [WIDTH-1:0] out_data_reg, out_data_next;
	logic push, pop;

	assign in_ready = in_ready_reg;
	assign out_valid = out_valid_reg;
	assign out_data = out_data_reg;

	always_comb begin
		push = in_valid & in_ready_reg;
		pop = (cnt_reg != '0) & (~out_valid_reg | out_ready);
		wptr_next = push ? wptr_reg + AW'(1) : wptr_reg;
		rptr_next = pop ? rptr_reg + AW'(1) : rptr_reg;
		cnt_next = cnt_reg + (AW+1)'(push) - (AW+1)'(pop);
		// ready drops only when the store is truly full
		in_ready_next = cnt_next < (AW+1)'(DEPTH);
		out_valid_next = out_valid_reg;
		out_data_next = out_data_reg;
		if (pop) begin
			out_valid_next = 1'b1;
			out_data_next = mem[rptr_reg];
		end else if (out_ready) begin
			out_valid_next = 1'b0;
		end
	end

	always_ff @(posedge clk_sys) begin
		if (push) begin
			mem[wptr_reg] <= in_data;
		end
		if (!rst_n) begin
			wptr_reg <= '0;
			rptr_reg <= '0;
			cnt_reg <= '0;
			in_ready_reg <= 1'b0;
			out_valid_reg <= 1'b0;
			out_data_reg <= '0;
		end else begin
			wptr_reg <= wptr_next;
			rptr_reg <= rptr_next;
			cnt_reg <= cnt_next;
			in_ready_reg <= in_ready_next;
			out_valid_reg <= out_valid_next;
			out_data_reg <= out_data_next;
		end
	end
endmodule
`default_nettype wire

// [verif/crs_dev_model.sv]
// device register space model answering the scheduler's reads
`timescale 1ns/1ns
`default_nettype none
module crs_dev_model (
	// clock and reset
	input wire logic clk_sys,
	input wire logic rst_n,
	// register read port
	input wire logic dev_rd_req,
	input wire logic [31:0] dev_rd_addr,
	output logic dev_rd_ack,
	output logic [31:0] dev_rd_data
);
	logic [1:0] wait_reg;
	// every sixteenth word reads zero, so some gate reads refuse
	function automatic logic [31:0] dev_val(input logic [31:0] a);
		return (a[3:0] == 4'h0) ? 32'h0000_0000 : a ^ 32'hc3c3_0000;
	endfunction
	// latency drawn anew per read; data toggles outside answers so no stale value passes
	always @(posedge clk_sys) begin
		if (!rst_n) begin
			dev_rd_ack <= 1'b0;
			wait_reg <= 2'h0;
			dev_rd_data <= 32'h0000_0000;
		end else if (dev_rd_ack) begin
			dev_rd_ack <= 1'b0;
			dev_rd_data <= ~dev_rd_data;
			wait_reg <= 2'($urandom_range(3, 0));
		end else if (dev_rd_req && wait_reg == 2'h0) begin
			dev_rd_ack <= 1'b1;
			dev_rd_data <= dev_val(dev_rd_addr);
		end else begin
			dev_rd_data <= ~dev_rd_data;
			if (dev_rd_req)
				wait_reg <= wait_reg - 2'h1;
		end
	end
endmodule
`default_nettype wire

// [verif/crs_sched_tb_top.sv]
// self-checking bench for the CAN report scheduler
`timescale 1ns/1ns
`default_nettype none
module crs_sched_tb_top;
	import crs_pkg::*;
	logic clk_sys = 1'b0;
	logic rst_n;
	logic [11:0] s_awaddr, s_araddr;
	logic [31:0] s_wdata, s_rdata, dev_rd_addr, dev_rd_data, tx_data;
	logic [3:0] s_wstrb;
	logic [1:0] s_bresp, s_rresp;
	logic s_awvalid, s_awready, s_wvalid, s_wready, s_bvalid, s_bready;
	logic s_arvalid, s_arready, s_rvalid, s_rready;
	logic dev_rd_req, dev_rd_ack, tx_valid, tx_ready, stall;
	logic [10:0] tx_id, base;
	logic [31:0] slot_a [64];
	logic [31:0] b_w [4][4];
	logic [CRS_FRAME_W-1:0] exp_q [$];
	logic [CRS_FRAME_W-1:0] got_q [$];
	int n_mismatch = 0;
	int check_count = 0;
	int cyc = 0;
	int sent_total = 0;
	crs_sched i_crs_sched (.clk_sys(clk_sys), .rst_n(rst_n),
		.s_awaddr(s_awaddr), .s_awvalid(s_awvalid), .s_awready(s_awready),
		.s_wdata(s_wdata), .s_wstrb(s_wstrb), .s_wvalid(s_wvalid), .s_wready(s_wready),
		.s_bresp(s_bresp), .s_bvalid(s_bvalid), .s_bready(s_bready),
		.s_araddr(s_araddr), .s_arvalid(s_arvalid), .s_arready(s_arready),
		.s_rdata(s_rdata), .s_rresp(s_rresp), .s_rvalid(s_rvalid), .s_rready(s_rready),
		.dev_rd_req(dev_rd_req), .dev_rd_addr(dev_rd_addr), .dev_rd_ack(dev_rd_ack),
		.dev_rd_data(dev_rd_data), .tx_valid(tx_valid), .tx_ready(tx_ready),
		.tx_id(tx_id), .tx_data(tx_data));
	crs_dev_model i_crs_dev_model (.clk_sys(clk_sys), .rst_n(rst_n),
		.dev_rd_req(dev_rd_req), .dev_rd_addr(dev_rd_addr),
		.dev_rd_ack(dev_rd_ack), .dev_rd_data(dev_rd_data));
	// ****************************************
	// clock, sink, timeout
	// ****************************************
	always #4 clk_sys = ~clk_sys;
	always @(posedge clk_sys) begin
		tx_ready <= !stall && ($urandom_range(3, 0) != 0);
		if (tx_valid && tx_ready)
			got_q.push_back({tx_id, tx_data});
		cyc <= cyc + 1;
		if (cyc == 40000) begin
			n_mismatch++;
			summarize();
		end
	end
	// ****************************************
	// compare and bus tasks
	// ****************************************
	task automatic cmp_word(input string nm, input logic [31:0] e, input logic [31:0] s);
		check_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value %s expected %h seen %h", nm, e, s);
		end
	endtask
	task automatic cmp_frame(input logic [CRS_FRAME_W-1:0] e, input logic [CRS_FRAME_W-1:0] s);
		check_count++;
		if (s !== e) begin
			n_mismatch++;
			$display("wrong value frame expected %h seen %h", e, s);
		end
	endtask
	task automatic chk_wr(input logic [11:0] a, input logic [31:0] d, input logic [1:0] er);
		logic aw, w, b;
		@(posedge clk_sys);
		s_awaddr <= a;
		s_awvalid <= 1'b1;
		s_wdata <= d;
		s_wvalid <= 1'b1;
		s_bready <= 1'b1;
		aw = 1'b1;
		w = 1'b1;
		b = 1'b1;
		while (b) begin
			@(posedge clk_sys);
			if (aw && s_awready) begin
				aw = 1'b0;
				s_awvalid <= 1'b0;
			end
			if (w && s_wready) begin
				w = 1'b0;
				s_wvalid <= 1'b0;
			end
			if (s_bvalid) begin
				b = 1'b0;
				s_bready <= 1'b0;
				cmp_word("bresp", 32'(er), 32'(s_bresp));
			end
		end
	endtask
	task automatic chk_rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
		logic r;
		@(posedge clk_sys);
		s_araddr <= a;
		s_arvalid <= 1'b1;
		s_rready <= 1'b1;
		r = 1'b1;
		while (r) begin
			@(posedge clk_sys);
			if (s_arvalid && s_arready)
				s_arvalid <= 1'b0;
			if (s_rvalid) begin
				r = 1'b0;
				s_rready <= 1'b0;
				cmp_word("rdata", ed, s_rdata);
				cmp_word("rresp", 32'(er), 32'(s_rresp));
			end
		end
	endtask
	task automatic summarize();
		$display("comparisons %0d mismatches %0d", check_count, n_mismatch);
		if (n_mismatch == 0 && check_count > 0)
			$display("All tests passed");
		else
			$display("Some tests failed");
		$finish;
	endtask
	// ****************************************
	// expectations
	// ****************************************
	// same register contents as the partner model serves
	function automatic logic [31:0] mdl_val(input logic [31:0] a);
		return (a[3:0] == 4'h0) ? 32'h0000_0000 : a ^ 32'hc3c3_0000;
	endfunction
	function automatic logic [11:0] ba(input int b, input int f);
		return CRS_OFF_BULK + 12'(16 * b + 4 * f);
	endfunction
	function automatic void build();
		logic [10:0] id;
		logic [31:0] ga;
		exp_q.delete();
		for (int i = 0; i < 64; i++)
			if (slot_a[i] != 0)
				exp_q.push_back({base + 11'(i), mdl_val(slot_a[i])});
		id = base + CRS_BULK_ID_GAP;
		for (int b = 0; b < 4; b++) begin
			for (int e = 0; e < int'(b_w[b][3]); e++) begin
				ga = b_w[b][1] + b_w[b][2] * 32'(e);
				if (b_w[b][0] != 0 && mdl_val(ga) != 0)
					exp_q.push_back({id + 11'(e), mdl_val(b_w[b][0] + b_w[b][2] * 32'(e))});
			end
			id = id + 11'(b_w[b][3]);
		end
	endfunction
	// round 2 draws a new base id and grows block zero by 16, so later blocks' ids must move
	task automatic setup(input int r);
		base = (r == 0) ? 11'h100 : 11'($urandom_range(32'h500, 0));
		for (int i = 0; i < 64 && r < 2; i++)
			slot_a[i] = ((r == 0 && i > 18) || $urandom_range(3, 0) == 0) ? 0 :
				32'h1000 + $urandom_range(32'hfff, 0);
		for (int b = 0; b < 4 && r < 2; b++) begin
			b_w[b][0] = (r == 0 && b == 2) ? 0 : 32'h2000 + $urandom_range(32'hfff, 0);
			b_w[b][1] = 32'h8000 + $urandom_range(32'hfff, 0);
			b_w[b][2] = $urandom_range(5, 1);
			b_w[b][3] = (b == 0) ? 16 * $urandom_range(2, 1) : 8 * $urandom_range(2, 0);
		end
		if (r == 2)
			b_w[0][3] = b_w[0][3] + 32'd16;
		chk_wr(CRS_OFF_BASE_ID, {21'h0, base}, CRS_RESP_OKAY);
		for (int i = 0; i < 64; i++)
			chk_wr(CRS_OFF_SLOT + 12'(4 * i), slot_a[i], CRS_RESP_OKAY);
		for (int b = 0; b < 4; b++) begin
			for (int f = 0; f < 4; f++)
				chk_wr(ba(b, f), b_w[b][f], CRS_RESP_OKAY);
			chk_rd(ba(b, 3), b_w[b][3], CRS_RESP_OKAY);
		end
	endtask
	// ****************************************
	// main sequence
	// ****************************************
	initial begin
		rst_n <= 1'b0;
		stall <= 1'b0;
		s_awaddr <= 12'h000;
		s_araddr <= 12'h000;
		s_wdata <= 32'h0000_0000;
		s_wstrb <= 4'hf;
		{s_awvalid, s_wvalid, s_bready, s_arvalid, s_rready} <= 5'h00;
		void'($urandom(32'hcb35));
		repeat (20) @(posedge clk_sys);
		rst_n <= 1'b1;
		chk_rd(CRS_OFF_CTRL, CRS_WORD_RST, CRS_RESP_OKAY);
		chk_rd(CRS_OFF_BASE_ID, CRS_WORD_RST, CRS_RESP_OKAY);
		chk_rd(CRS_OFF_SENT, CRS_WORD_RST, CRS_RESP_OKAY);
		chk_rd(CRS_OFF_BULK_END, CRS_WORD_RST, CRS_RESP_OKAY);
		chk_rd(CRS_OFF_SLOT_END, CRS_WORD_RST, CRS_RESP_OKAY);
		chk_rd(12'h800, 32'h0000_0000, CRS_RESP_SLVERR);
		chk_wr(12'h800, 32'hffff_ffff, CRS_RESP_SLVERR);
		chk_wr(CRS_OFF_STATUS, 32'hffff_ffff, CRS_RESP_OKAY);
		chk_rd(CRS_OFF_STATUS, CRS_WORD_RST, CRS_RESP_OKAY);
		// partial strobe: only the low two byte lanes may change
		s_wstrb <= 4'h3;
		chk_wr(ba(3, 2), 32'hffff_ffff, CRS_RESP_OKAY);
		s_wstrb <= 4'hf;
		chk_rd(ba(3, 2), 32'h0000_ffff, CRS_RESP_OKAY);
		for (int r = 0; r < 3; r++) begin
			setup(r);
			build();
			got_q.delete();
			chk_wr(CRS_OFF_CTRL, 32'h0000_0002, CRS_RESP_OKAY);
			if (r == 1) begin
				stall <= 1'b1;
				repeat (300) @(posedge clk_sys);
				cmp_word("tx_valid", 32'h0000_0001, 32'(tx_valid));
				stall <= 1'b0;
			end
			while (got_q.size() < exp_q.size())
				@(posedge clk_sys);
			repeat (50) @(posedge clk_sys);
			cmp_word("frame count", 32'(exp_q.size()), 32'(got_q.size()));
			foreach (exp_q[i])
				cmp_frame(exp_q[i], (i < got_q.size()) ? got_q[i] : 'x);
			sent_total += exp_q.size();
			chk_rd(CRS_OFF_SENT, 32'(sent_total), CRS_RESP_OKAY);
			chk_rd(CRS_OFF_STATUS, CRS_WORD_RST, CRS_RESP_OKAY);
		end
		// free-running mode: two back-to-back rounds repeat the same frames
		got_q.delete();
		chk_wr(CRS_OFF_CTRL, 32'h0000_0001, CRS_RESP_OKAY);
		chk_rd(CRS_OFF_CTRL, 32'h0000_0001, CRS_RESP_OKAY);
		while (got_q.size() < 2 * exp_q.size())
			@(posedge clk_sys);
		chk_wr(CRS_OFF_CTRL, 32'h0000_0000, CRS_RESP_OKAY);
		for (int i = 0; i < 2 * exp_q.size(); i++)
			cmp_frame(exp_q[i % exp_q.size()], got_q[i]);
		summarize();
	end
endmodule
`default_nettype wire
